// ### mftr_apb_slave.sv
// apb slave handshake with registered answer for the terminal router
`timescale 1ns/100ps
module mftr_apb_slave
  import mftr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] rdata_in,
  input wire logic hit_in,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic wr_stb
);

  // ************************************************************
  // answer registers
  // ************************************************************
  // answer is prepared in the setup cycle so that every bus output
  // comes from a flop; the cost is a fixed one-cycle access phase
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      // setup cycle: capture read word and decode result
      pready <= 1'b1;
      prdata <= (hit_in && !pwrite) ? rdata_in : '0;
      pslverr <= !hit_in;
    end
    else
    begin
      // access phase done or idle: drop the answer
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
  end

  // write takes effect only at the completing access edge
  assign wr_stb = psel && penable && pready && pwrite && !pslverr;

endmodule

// ### mftr_board_model.sv
// board side of the terminals: resolves each pad level
`timescale 1ns/100ps
module mftr_board_model
(
  input wire logic [7:0] term_out,
  input wire logic [7:0] term_oe,
  input wire logic [7:0] board_lvl,
  output logic [7:0] term_in
);
  // ************************************************************
  // pad resolution
  // ************************************************************
  // board drivers are strong, so a released pad shows the board level
  always_comb
  begin
    term_in = (term_oe & term_out) | (~term_oe & board_lvl);
  end
endmodule

// ### mftr_gpi_event.sv
// change detector and sticky event flags for the general inputs
`timescale 1ns/100ps
module mftr_gpi_event
  import mftr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] level,
  input wire logic [2:0] routed,
  input wire logic [2:0] clr,
  output logic [2:0] status
);

  logic [2:0] prev_r; // level seen one cycle before
  logic [2:0] set_w; // change seen this cycle

  // a change counts only while the terminal is a general input
  assign set_w = routed & (level ^ prev_r);

  // ************************************************************
  // previous level
  // ************************************************************
  // sampled always, so a terminal switched to input starts clean
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      prev_r <= '0;
    else
      prev_r <= level;
  end

  // ************************************************************
  // sticky flags
  // ************************************************************
  // a change in the clearing cycle survives: set wins over clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      status <= MFTR_EVT_RST;
    else
      status <= (status & ~clr) | set_w;
  end

endmodule

// ### mftr_pkg.sv
// constants, codes and carrier structs of the multifunction terminal router
package mftr_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int MFTR_ADDR_W = 12; // apb byte address width
  localparam int MFTR_DATA_W = 32; // apb data width

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [11:0] MFTR_OFS_EVT = 12'h080; // input event status
  localparam logic [11:0] MFTR_OFS_GPO = 12'h084; // general output data
  localparam logic [11:0] MFTR_OFS_GPI = 12'h088; // general input levels
  localparam logic [11:0] MFTR_OFS_ROUTE = 12'h08c; // terminal routing

  // ************************************************************
  // routing register layout and reset values
  // ************************************************************
  localparam int MFTR_NTERM = 8; // multifunction terminals
  localparam int MFTR_SEL_W = 3; // select field width
  localparam int MFTR_FIELD_STRIDE = 4; // field pitch in bits
  localparam int MFTR_NGPI = 3; // general inputs 0..2
  localparam logic [31:0] MFTR_ROUTE_RST = 32'h0000_0000;
  localparam logic [31:0] MFTR_ROUTE_MASK = 32'h7777_7777; // no bit 3,7..
  localparam logic [2:0] MFTR_EVT_RST = 3'h0;
  localparam logic [1:0] MFTR_GPO_RST = 2'h0; // general outputs 3..2
  localparam int MFTR_GPO_LSB = 2; // gpo bits sit at 3..2

  // ************************************************************
  // select codes, named by their binary value
  // ************************************************************
  typedef enum logic [2:0] {
    MFTR_C0 = 3'b000,
    MFTR_C1 = 3'b001,
    MFTR_C2 = 3'b010,
    MFTR_C3 = 3'b011,
    MFTR_C4 = 3'b100,
    MFTR_C5 = 3'b101,
    MFTR_C6 = 3'b110,
    MFTR_C7 = 3'b111
  } mftr_sel_e;

  // ************************************************************
  // carriers between the core and the router
  // ************************************************************
  // core functions that may be driven out on a terminal
  typedef struct packed {
    logic interrupt_line_c;
    logic low_power_state_indicator;
    logic card_video_clock;
    logic ring_indicate_output;
    logic link_activity_led;
    logic socket1_activity_led;
    logic socket2_activity_led;
    logic general_event_output;
    logic card_audio_pwm;
    logic video_port_status;
    logic lock_signal;
  } mftr_src_s;

  // terminal levels handed to the core
  typedef struct packed {
    logic [2:0] general_input;
    logic card_bus_grant;
  } mftr_sink_s;

endpackage

// ### mftr_properties.sv
// concurrent checks on the terminal router ports
`timescale 1ns/100ps
module mftr_properties
  import mftr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [7:0] term_in,
  input wire logic [7:0] term_oe,
  input wire mftr_pkg::mftr_sink_s fn_sink
);
  // ************************************************************
  // one clock domain, reset disables every check
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // setup cycle, then a one-cycle answer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_ready_once: assert property (s_setup |=> s_answer)
    else $error("answer not one cycle after setup");
  a_unmapped_err: assert property ((psel && !penable && paddr == 12'h090)
    |=> pready && pslverr)
    else $error("unmapped access not refused");
  a_route_resvd: assert property ((pready && !pslverr && !pwrite
    && paddr == 12'h08c) |-> (prdata & 32'h8888_8888) == 32'h0)
    else $error("reserved routing bits read nonzero");
  a_error_quiet: assert property ((pready && pslverr) |-> prdata == 32'h0)
    else $error("refused read carried data");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read bus active outside answer");
  a_fixed_undriven: assert property (!term_oe[0] && !term_oe[1])
    else $error("input-only terminal driven");
  a_t6_undriven: assert property (!term_oe[6])
    else $error("terminal 6 driven");
  a_gpi_follows: assert property
    ((fn_sink.general_input & ~$past(term_in[2:0])) == 3'h0)
    else $error("general input not from terminal level");
  a_grant_follows: assert property
    (fn_sink.card_bus_grant |-> $past(term_in[2]))
    else $error("grant not from terminal 2");
endmodule
bind mftr_top mftr_properties u_mftr_properties (.mclk(mclk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .term_in(term_in), .term_oe(term_oe), .fn_sink(fn_sink));

// ### mftr_top.sv
// multifunction terminal router: routing register and pin multiplexer
`timescale 1ns/100ps
module mftr_top
  import mftr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // serial rom preload of the routing word
  input wire logic rom_load_valid,
  input wire logic [31:0] rom_load_data,
  // terminals, split into level, drive value and drive enable
  input wire logic [7:0] term_in,
  output logic [7:0] term_out,
  output logic [7:0] term_oe,
  // core side
  input wire mftr_pkg::mftr_src_s fn_src,
  output mftr_pkg::mftr_sink_s fn_sink
);

  import mftr_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  logic [31:0] route_r; // terminal routing word
  logic [1:0] gpo_r; // general output data, bits 3..2
  logic [2:0] evt_w; // sticky input event flags
  logic [2:0] evt_clr_w; // write-one-to-clear mask
  logic [2:0] gpi_routed_w; // terminals 0..2 act as inputs
  logic grant_routed_w; // terminal 2 carries the grant
  logic wr_stb_w; // completing apb write
  logic hit_w; // address decodes to a register
  logic [31:0] rdata_w; // word for the addressed register
  logic [7:0] term_out_r; // registered drive values
  logic [7:0] term_oe_r; // registered drive enables
  mftr_sink_s sink_r; // registered core-side levels

  // ************************************************************
  // helper functions
  // ************************************************************
  // pick the 3-bit select field of one terminal from the word
  function automatic mftr_sel_e field_sel(input logic [31:0] word,
                                          input logic [2:0] idx);
    int base;
    base = int'(idx) * MFTR_FIELD_STRIDE;
    field_sel = mftr_sel_e'(word[base +: MFTR_SEL_W]);
  endfunction

  // drive enable and value of one terminal; {oe, out}
  // unknown or reserved codes fall to the default: pin left floating
  function automatic logic [1:0] route_out(input logic [2:0] idx,
                                           input mftr_sel_e sel,
                                           input mftr_src_s src,
                                           input logic [1:0] gpo);
    route_out = 2'b00;
    unique case (idx)
      3'd2:
      begin
        unique case (sel)
          // 000 general input and 011 grant are inputs: no drive
          MFTR_C1: route_out = {1'b1, gpo[0]};
          MFTR_C2: route_out = {1'b1, src.interrupt_line_c};
          MFTR_C4:
            route_out = {1'b1, src.low_power_state_indicator};
          MFTR_C7: route_out = {1'b1, src.card_video_clock};
          default: route_out = 2'b00;
        endcase
      end
      3'd3:
      begin
        unique case (sel)
          MFTR_C1: route_out = {1'b1, gpo[1]};
          MFTR_C2: route_out = {1'b1, src.socket2_activity_led};
          MFTR_C5: route_out = {1'b1, src.lock_signal};
          MFTR_C7: route_out = {1'b1, src.card_video_clock};
          default: route_out = 2'b00;
        endcase
      end
      3'd4:
      begin
        unique case (sel)
          // 001 stays reserved and undriven
          MFTR_C2: route_out = {1'b1, src.socket1_activity_led};
          MFTR_C5: route_out = {1'b1, src.general_event_output};
          MFTR_C7: route_out = {1'b1, src.video_port_status};
          default: route_out = 2'b00;
        endcase
      end
      3'd5:
      begin
        unique case (sel)
          // 001 stays reserved and undriven
          MFTR_C2: route_out = {1'b1, src.link_activity_led};
          MFTR_C5: route_out = {1'b1, src.general_event_output};
          MFTR_C6: route_out = {1'b1, src.card_audio_pwm};
          default: route_out = 2'b00;
        endcase
      end
      3'd7:
      begin
        unique case (sel)
          MFTR_C1: route_out = {1'b1, src.ring_indicate_output};
          MFTR_C2: route_out = {1'b1, src.link_activity_led};
          MFTR_C4: route_out = {1'b1, src.low_power_state_indicator};
          MFTR_C5: route_out = {1'b1, src.lock_signal};
          default: route_out = 2'b00;
        endcase
      end
      // terminals 0, 1 offer only an input; 6 has no known function
      default: route_out = 2'b00;
    endcase
  endfunction

  // ************************************************************
  // input routing decode
  // ************************************************************
  // code 000 makes terminals 0..2 general inputs
  always_comb
  begin
    gpi_routed_w[0] = (field_sel(route_r, 3'd0) == MFTR_C0);
    gpi_routed_w[1] = (field_sel(route_r, 3'd1) == MFTR_C0);
    gpi_routed_w[2] = (field_sel(route_r, 3'd2) == MFTR_C0);
  end

  // code 011 on terminal 2 takes the card bus grant in
  assign grant_routed_w = (field_sel(route_r, 3'd2) == MFTR_C3);

  // ************************************************************
  // register bus decode and read mux
  // ************************************************************
  // all 12 address bits are decoded and none are ignored;
  // a misaligned or unmapped access answers with pslverr
  always_comb
  begin
    hit_w = 1'b1;
    rdata_w = '0;
    unique case (paddr)
      MFTR_OFS_EVT:
        rdata_w = {29'h0, evt_w};
      MFTR_OFS_GPO:
        rdata_w = {28'h0, gpo_r, 2'h0};
      MFTR_OFS_GPI:
        rdata_w = {29'h0, sink_r.general_input};
      MFTR_OFS_ROUTE:
        rdata_w = route_r & MFTR_ROUTE_MASK;
      default:
        hit_w = 1'b0;
    endcase
  end

  // bus handshake with a registered answer
  mftr_apb_slave u_apb (
    .mclk (mclk),
    .rst_n (rst_n),
    .psel (psel),
    .penable (penable),
    .pwrite (pwrite),
    .rdata_in (rdata_w),
    .hit_in (hit_w),
    .pready (pready),
    .prdata (prdata),
    .pslverr (pslverr),
    .wr_stb (wr_stb_w)
  );

  // ************************************************************
  // routing register
  // ************************************************************
  // a rom preload beats a bus write in the same cycle, since the
  // preload is the power-on value; reserved bits never store
  // the word is meant to be set once at power-on: a later change
  // re-routes pins mid-operation and may glitch them
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      route_r <= MFTR_ROUTE_RST;
    else if (rom_load_valid)
      route_r <= rom_load_data & MFTR_ROUTE_MASK;
    else if (wr_stb_w && paddr == MFTR_OFS_ROUTE)
      route_r <= pwdata & MFTR_ROUTE_MASK;
  end

  // ************************************************************
  // general output register
  // ************************************************************
  // only outputs 3..2 have a terminal in this block
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      gpo_r <= MFTR_GPO_RST;
    else if (wr_stb_w && paddr == MFTR_OFS_GPO)
      gpo_r <= pwdata[MFTR_GPO_LSB +: 2];
  end

  // ************************************************************
  // input event flags
  // ************************************************************
  // software clears a flag by writing one to it
  assign evt_clr_w = (wr_stb_w && paddr == MFTR_OFS_EVT) ?
                     pwdata[2:0] : 3'h0;

  mftr_gpi_event u_evt (
    .mclk (mclk),
    .rst_n (rst_n),
    .level (term_in[2:0]),
    .routed (gpi_routed_w),
    .clr (evt_clr_w),
    .status (evt_w)
  );

  // ************************************************************
  // terminal drivers
  // ************************************************************
  // one flop stage on every pin; the core functions reach the pins
  // one cycle late, which keeps the pins free of decode glitches
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      term_out_r <= '0;
      term_oe_r <= '0;
    end
    else
    begin
      for (int i = 0; i < MFTR_NTERM; i++)
      begin
        {term_oe_r[i], term_out_r[i]} <=
          route_out(3'(i), field_sel(route_r, 3'(i)), fn_src, gpo_r);
      end
    end
  end

  assign term_out = term_out_r;
  assign term_oe = term_oe_r;

  // ************************************************************
  // core-side levels
  // ************************************************************
  // an input not routed reads zero so no stray pin level leaks in
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sink_r <= '0;
    else
    begin
      sink_r.general_input <= term_in[2:0] & gpi_routed_w;
      sink_r.card_bus_grant <= term_in[2] & grant_routed_w;
    end
  end

  assign fn_sink = sink_r;

endmodule

// ### mftr_top_bench.sv
// self-checking bench for the terminal router
`timescale 1ns/100ps
module mftr_top_bench;
  import mftr_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic rom_load_valid = 1'b0;
  logic [31:0] rom_load_data = 32'h0;
  logic [7:0] term_in;
  logic [7:0] term_out;
  logic [7:0] term_oe;
  logic [7:0] board = 8'h0;
  mftr_src_s fn_src = '0;
  mftr_sink_s fn_sink;
  int err_count = 0;
  int checks = 0;
  // codes per terminal that drive the pad, bit index = code
  logic [7:0] dmask [8] = '{8'h00, 8'h00, 8'h96, 8'ha6, 8'ha4, 8'h64,
    8'h00, 8'h36};
  // ************************************************************
  // clock, design and board
  // ************************************************************
  always #12.5 mclk = ~mclk;
  mftr_top u_mftr_top (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rom_load_valid(rom_load_valid), .rom_load_data(rom_load_data),
    .term_in(term_in), .term_out(term_out), .term_oe(term_oe),
    .fn_src(fn_src), .fn_sink(fn_sink));
  mftr_board_model u_mftr_board_model (.term_out(term_out),
    .term_oe(term_oe), .board_lvl(board), .term_in(term_in));
  // ************************************************************
  // compare and bus tasks
  // ************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // entered just after a rising edge; ends after an idle edge
  // the request stands until the rising edge that samples pready high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    input logic [31:0] exp, input logic experr);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50)
      err_count++;
    if (!w)
      chk(prdata, exp);
    chk1(pslverr, experr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0, 1'b0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic er);
    apb(a, 1'b0, 32'h0, e, er);
  endtask
  task complete_run;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ************************************************************
  // watchdog: about sixteen times the expected run
  // ************************************************************
  initial
  begin
    #(25 * 20000);
    err_count++;
    complete_run();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    logic v;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(MFTR_OFS_ROUTE, 32'h0, 1'b0);
    rd(12'h090, 32'h0, 1'b1);
    rd(12'h08d, 32'h0, 1'b1);
    wr(MFTR_OFS_ROUTE, 32'hffff_ffff);
    rd(MFTR_OFS_ROUTE, 32'h7777_7777, 1'b0);
    wr(MFTR_OFS_GPO, 32'hffff_ffff);
    rd(MFTR_OFS_GPO, 32'h0000_000c, 1'b0);
    // every code on every terminal, with all sources low then high
    for (int t = 0; t < 8; t++)
      for (int c = 0; c < 8; c++)
        for (int k = 0; k < 2; k++)
        begin
          v = k[0];
          fn_src <= {11{v}};
          board <= {8{v}};
          wr(MFTR_OFS_GPO, v ? 32'hc : 32'h0);
          wr(MFTR_OFS_ROUTE, 32'(c) << (4 * t));
          repeat (2) @(posedge mclk);
          @(negedge mclk);
          chk1(term_oe[t], dmask[t][c]);
          if (dmask[t][c])
            chk1(term_out[t], v);
          if (t < 3 && !(t == 2 && c == 3))
            chk1(fn_sink.general_input[t], c == 0 ? v : 1'b0);
          if (t == 2)
            chk1(fn_sink.card_bus_grant, c == 3 ? v : 1'b0);
          @(posedge mclk);
        end
    // level change flags an event only on a routed input
    board <= 8'h00;
    wr(MFTR_OFS_ROUTE, 32'h0);
    repeat (3) @(posedge mclk);
    wr(MFTR_OFS_EVT, 32'h7);
    rd(MFTR_OFS_EVT, 32'h0, 1'b0);
    board <= 8'h02;
    repeat (3) @(posedge mclk);
    rd(MFTR_OFS_EVT, 32'h2, 1'b0);
    rd(MFTR_OFS_GPI, 32'h2, 1'b0);
    wr(MFTR_OFS_EVT, 32'h2);
    rd(MFTR_OFS_EVT, 32'h0, 1'b0);
    wr(MFTR_OFS_ROUTE, 32'h10);
    board <= 8'h00;
    repeat (3) @(posedge mclk);
    rd(MFTR_OFS_EVT, 32'h0, 1'b0);
    rd(MFTR_OFS_GPI, 32'h0, 1'b0);
    // serial rom preload, reserved bits dropped
    rom_load_valid <= 1'b1;
    rom_load_data <= 32'hffff_ffff;
    @(posedge mclk);
    rom_load_valid <= 1'b0;
    @(posedge mclk);
    rd(MFTR_OFS_ROUTE, 32'h7777_7777, 1'b0);
    // second reset in mid-run clears the preloaded word
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(MFTR_OFS_ROUTE, 32'h0, 1'b0);
    complete_run();
  end
endmodule
